// >>> core/dpt_top.sv
// APB front end streaming the discoverable parameter table
//
// Overview of operation
// - Table reached only by read command 5AH
// - Header pointer names offset 30H
// - Byte 30H bits 1:0 read 01b
// - Byte 30H bit 2 reads 1
// - Bits 3,4 zero; byte 30H is E5H
// - Byte 30H bits 7:5 fixed at 111b
// - Address width field reads 00b
// - No double rate; byte 32H is F1H
// - Four fast read variants flagged supported
// - 1-4-4: 4 dummies, 2 mode bits, EBH
// - 1-1-4: 8 dummies, no mode, 6BH
// - 1-1-2: 8 dummies, no mode, 3BH
// - 1-2-2: byte 42H, opcode BBH
// - Byte 40H FEH; 2-2-2 absent
// - 4-4-4: byte 44H, opcode EBH at 4BH
// - Sector type one 0CH, opcode 20H
// - Sector type two 0FH, opcode 52H
// - Sector type three 10H, opcode D8H
// - Sector type four absent, opcode FFH
`timescale 1ns/1ps
`include "dpt_defs.svh"

module dpt_top
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o
);

    localparam int LANES = 4;

    ////////////////////////////////////////////////////////////////////////
    // Session state and decode

    dpt_pkg::dpt_sel_t sel;
    logic [31:0] cmd;
    logic [23:0] offset;
    logic active;
    logic bad_op;
    logic acc;
    logic wr_acc;
    logic rd_acc;
    logic bus_err;
    logic rd_fire;
    logic dw_fire;
    logic op_ok;
    logic [7:0] lane_byte [LANES];
    logic [31:0] dword;
    logic [31:0] stat_word;

    // Taken once per access; pready then closes the transfer
    assign acc = ce_i && psel_i && penable_i && !pready_o;
    assign wr_acc = acc && pwrite_i;
    assign rd_acc = acc && !pwrite_i;
    assign op_ok = pwdata_i[`DPT_CMD_OP_MSB:`DPT_CMD_OP_LSB]
                   == `DPT_RD_OPCODE;

    always_comb
    begin
        case (paddr_i)
            `DPT_OFS_CMD: sel = dpt_pkg::SEL_CMD;
            `DPT_OFS_DATA: sel = dpt_pkg::SEL_DATA;
            `DPT_OFS_STAT: sel = dpt_pkg::SEL_STAT;
            `DPT_OFS_DWRD: sel = dpt_pkg::SEL_DWRD;
            default: sel = dpt_pkg::SEL_NONE;
        endcase
    end

    // Stream reads only make sense inside an open session
    always_comb
    begin
        case (sel)
            dpt_pkg::SEL_CMD: bus_err = pwrite_i && pstrb_i != 4'hF;
            dpt_pkg::SEL_STAT: bus_err = 1'b0;
            dpt_pkg::SEL_DATA: bus_err = pwrite_i || !active;
            dpt_pkg::SEL_DWRD: bus_err = pwrite_i || !active;
            default: bus_err = 1'b1;
        endcase
    end

    assign rd_fire = rd_acc && sel == dpt_pkg::SEL_DATA && active;
    assign dw_fire = rd_acc && sel == dpt_pkg::SEL_DWRD && active;

    ////////////////////////////////////////////////////////////////////////
    // Table lookup, one lane per byte of a word

    genvar g;
    generate
        for (g = 0; g < LANES; g++)
        begin : g_lane
            dpt_rom u_rom
            (
                .addr_i(offset + 24'(g)),
                .byte_o(lane_byte[g])
            );
        end
    endgenerate

    // Lowest offset lands in the lowest byte lane
    assign dword = {lane_byte[3], lane_byte[2], lane_byte[1], lane_byte[0]};

    assign stat_word = {offset, 6'h00, bad_op, active};

    ////////////////////////////////////////////////////////////////////////
    // APB answer

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pready_o <= 1'b0;
        end
        else if (ce_i)
        begin
            pready_o <= acc;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pslverr_o <= 1'b0;
        end
        else if (acc)
        begin
            pslverr_o <= bus_err;
        end
        else if (ce_i)
        begin
            pslverr_o <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            prdata_o <= 32'h0000_0000;
        end
        else if (rd_acc)
        begin
            case (sel)
                dpt_pkg::SEL_CMD: prdata_o <= cmd;
                dpt_pkg::SEL_STAT: prdata_o <= stat_word;
                dpt_pkg::SEL_DATA:
                    prdata_o <= active ? {24'h000000, lane_byte[0]}
                                       : 32'h0000_0000;
                dpt_pkg::SEL_DWRD:
                    prdata_o <= active ? dword : 32'h0000_0000;
                default: prdata_o <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command, session and offset

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cmd <= `DPT_CMD_RST;
        end
        else if (wr_acc && sel == dpt_pkg::SEL_CMD && !bus_err)
        begin
            cmd <= pwdata_i;
        end
    end

    // Any other opcode never opens the table
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            active <= 1'b0;
        end
        else if (wr_acc && sel == dpt_pkg::SEL_CMD && !bus_err)
        begin
            active <= op_ok;
        end
        else if (wr_acc && sel == dpt_pkg::SEL_STAT
                 && pwdata_i[`DPT_STAT_ACT_BIT])
        begin
            active <= 1'b0;
        end
    end

    // Set by a bad opcode, cleared by writing one to its status bit
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            bad_op <= 1'b0;
        end
        else if (wr_acc && sel == dpt_pkg::SEL_CMD && !bus_err)
        begin
            bad_op <= !op_ok;
        end
        else if (wr_acc && sel == dpt_pkg::SEL_STAT
                 && pwdata_i[`DPT_STAT_BAD_BIT])
        begin
            bad_op <= 1'b0;
        end
    end

    // Offset wraps at the top of the 24-bit space
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            offset <= `DPT_OFS_RST;
        end
        else if (wr_acc && sel == dpt_pkg::SEL_CMD && !bus_err && op_ok)
        begin
            offset <= pwdata_i[23:0];
        end
        else if (rd_fire)
        begin
            offset <= offset + 24'h000001;
        end
        else if (dw_fire)
        begin
            offset <= offset + 24'(LANES);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    property p_bad_op;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        wr_acc && sel == dpt_pkg::SEL_CMD && !bus_err && !op_ok
        |=> !active && bad_op ##1 pready_o == 1'b0;
    endproperty
    a_bad_op: assert property (p_bad_op)
        else $error("wrong opcode opened the table");

    property p_ptr;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        dw_fire && offset == 24'h00000C
        |=> prdata_o[23:0] == 24'h000030 && pready_o;
    endproperty
    a_ptr: assert property (p_ptr)
        else $error("table pointer not 30H");

    property p_b30;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        rd_fire && offset == 24'h000030 |=> prdata_o == 32'h0000_00E5;
    endproperty
    a_b30: assert property (p_b30)
        else $error("byte 30H wrong");

    property p_b32;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        dw_fire && offset == 24'h000030
        |=> prdata_o == 32'hFFF1_20E5;
    endproperty
    a_b32: assert property (p_b32)
        else $error("first table word wrong");

    property p_b38;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        dw_fire && offset == 24'h000038
        |=> prdata_o == 32'h6B08_EB44;
    endproperty
    a_b38: assert property (p_b38)
        else $error("quad read word wrong");

    property p_b3c;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        dw_fire && offset == 24'h00003C
        |=> prdata_o == 32'hBB42_3B08;
    endproperty
    a_b3c: assert property (p_b3c)
        else $error("dual read word wrong");

    property p_b40;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        rd_fire && offset == 24'h000040
        |=> prdata_o[7:0] == 8'hFE && prdata_o[31:8] == 24'h000000;
    endproperty
    a_b40: assert property (p_b40)
        else $error("byte 40H wrong");

    property p_b46;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        dw_fire && offset == 24'h000044
        |=> prdata_o == 32'hFF00_FFFF;
    endproperty
    a_b46: assert property (p_b46)
        else $error("dual quad word wrong");

    property p_b4a;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        dw_fire && offset == 24'h000048
        |=> prdata_o == 32'hEB44_FFFF;
    endproperty
    a_b4a: assert property (p_b4a)
        else $error("4-4-4 word wrong");

    property p_sec12;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        dw_fire && offset == 24'h00004C
        |=> prdata_o == 32'h520F_200C;
    endproperty
    a_sec12: assert property (p_sec12)
        else $error("sector types one and two wrong");

    property p_sec34;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        dw_fire && offset == 24'h000050
        |=> prdata_o == 32'hFF00_D810;
    endproperty
    a_sec34: assert property (p_sec34)
        else $error("sector types three and four wrong");

    property p_inc;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        rd_fire |=> offset == $past(offset) + 24'h000001;
    endproperty
    a_inc: assert property (p_inc)
        else $error("offset did not advance by one");

    property p_hold;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        !rd_fire && !dw_fire && !wr_acc |=> $stable(offset);
    endproperty
    a_hold: assert property (p_hold)
        else $error("offset moved without a read");

endmodule

// >>> include/dpt_defs.svh
// Offsets, field values and table bytes of the parameter table block
`ifndef DPT_DEFS_SVH
`define DPT_DEFS_SVH

// APB register byte addresses
`define DPT_OFS_CMD 12'h000
`define DPT_OFS_DATA 12'h004
`define DPT_OFS_STAT 12'h008
`define DPT_OFS_DWRD 12'h00C

// Command word fields
`define DPT_CMD_OP_MSB 31
`define DPT_CMD_OP_LSB 24
`define DPT_RD_OPCODE 8'h5A
`define DPT_CMD_RST 32'h0000_0000

// Status word fields
`define DPT_STAT_ACT_BIT 0
`define DPT_STAT_BAD_BIT 1
`define DPT_STAT_OFS_LSB 8

// Parameter space layout
`define DPT_OFS_RST 24'h000000
`define DPT_TBL_BASE 24'h000030
`define DPT_PTR_ADDR 24'h00000C
`define DPT_PTR_BYTE 8'h30
`define DPT_ZERO_BYTE 8'h00
`define DPT_UNUSED 8'hFF

// Table bytes, fields high to low
`define DPT_B30 {3'b111, 1'b0, 1'b0, 1'b1, 2'b01}
`define DPT_B31 8'h20
`define DPT_B32 {1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 2'b00, 1'b1}
`define DPT_B37 8'h07
`define DPT_B38 {3'b010, 5'b00100}
`define DPT_B39 8'hEB
`define DPT_B3A {3'b000, 5'b01000}
`define DPT_B3B 8'h6B
`define DPT_B3C {3'b000, 5'b01000}
`define DPT_B3D 8'h3B
`define DPT_B3E {3'b010, 5'b00010}
`define DPT_B3F 8'hBB
`define DPT_B40 {3'b111, 1'b1, 3'b111, 1'b0}
`define DPT_B46 {3'b000, 5'b00000}
`define DPT_B4A {3'b010, 5'b00100}
`define DPT_B4B 8'hEB
`define DPT_B4C 8'h0C
`define DPT_B4D 8'h20
`define DPT_B4E 8'h0F
`define DPT_B4F 8'h52
`define DPT_B50 8'h10
`define DPT_B51 8'hD8
`define DPT_B52 8'h00

`endif

// >>> include/dpt_pkg.sv
// Types shared by the parameter table block
package dpt_pkg;

    typedef enum logic [2:0]
    {
        SEL_CMD,
        SEL_DATA,
        SEL_STAT,
        SEL_DWRD,
        SEL_NONE
    } dpt_sel_t;

endpackage

// >>> core/dpt_rom.sv
// Constant parameter space lookup, one byte per address
`timescale 1ns/1ps
`include "dpt_defs.svh"

module dpt_rom
(
    input wire logic [23:0] addr_i,
    output logic [7:0] byte_o
);

    localparam int TBL_LEN = 36;

    // Basic table, offsets 30H up to 53H
    localparam logic [7:0] TBL [TBL_LEN] = '{
        `DPT_B30, `DPT_B31, `DPT_B32, `DPT_UNUSED,
        `DPT_UNUSED, `DPT_UNUSED, `DPT_UNUSED, `DPT_B37,
        `DPT_B38, `DPT_B39, `DPT_B3A, `DPT_B3B,
        `DPT_B3C, `DPT_B3D, `DPT_B3E, `DPT_B3F,
        `DPT_B40, `DPT_UNUSED, `DPT_UNUSED, `DPT_UNUSED,
        `DPT_UNUSED, `DPT_UNUSED, `DPT_B46, `DPT_UNUSED,
        `DPT_UNUSED, `DPT_UNUSED, `DPT_B4A, `DPT_B4B,
        `DPT_B4C, `DPT_B4D, `DPT_B4E, `DPT_B4F,
        `DPT_B50, `DPT_B51, `DPT_B52, `DPT_UNUSED
    };

    logic [23:0] idx;

    always_comb
    begin
        idx = addr_i - `DPT_TBL_BASE;
        byte_o = `DPT_UNUSED;
        if (addr_i >= `DPT_TBL_BASE && idx < 24'(TBL_LEN))
        begin
            byte_o = TBL[idx[5:0]];
        end
        else if (addr_i == `DPT_PTR_ADDR)
        begin
            byte_o = `DPT_PTR_BYTE;
        end
        else if (addr_i == `DPT_PTR_ADDR + 24'h000001
                 || addr_i == `DPT_PTR_ADDR + 24'h000002)
        begin
            // Upper pointer bytes
            byte_o = `DPT_ZERO_BYTE;
        end
    end

endmodule

// >>> tb/dpt_host.sv
// Bus host model reading the parameter space over APB
`timescale 1ns/1ps
module dpt_host
(
    input wire logic sys_clk_i,
    input wire logic pready_i,
    input wire logic pslverr_i,
    input wire logic [31:0] prdata_i,
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [11:0] paddr_o,
    output logic [31:0] pwdata_o,
    output logic [3:0] pstrb_o
);
    logic rdy_s;
    logic err_s;
    logic [31:0] dat_s;

    initial
    begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 12'hFFF;
        pwdata_o = 32'h00000000;
        pstrb_o = 4'h0;
    end

    // Answer settled mid-cycle, so it is what the next rising edge sees
    always @(negedge sys_clk_i)
    begin
        rdy_s <= pready_i;
        err_s <= pslverr_i;
        dat_s <= prdata_i;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic xfer(input logic wr, input logic [11:0] adr,
        input logic [31:0] wd, input logic [3:0] st,
        output logic [31:0] rd, output logic err, output bit ok);
        int n;
        @(posedge sys_clk_i);
        psel_o <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o <= wr;
        paddr_o <= adr;
        pwdata_o <= wd;
        pstrb_o <= st;
        @(posedge sys_clk_i);
        penable_o <= 1'b1;
        ok = 1'b0;
        for (n = 0; n < 64 && !ok; n++)
        begin
            @(posedge sys_clk_i);
            ok = (rdy_s === 1'b1);
        end
        rd = dat_s;
        err = err_s;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        // Released address and data inverted so a stale value never passes
        paddr_o <= ~adr;
        pwdata_o <= ~wd;
    endtask
endmodule

// >>> tb/discoverable_param_basic_table_test.sv
// Self-checking bench for the parameter table block
`timescale 1ns/1ps
module discoverable_param_basic_table_test;
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic ce_i = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    bit ok;
    int fails = 0;
    int check_count = 0;

    always #4 sys_clk_i = ~sys_clk_i;

    dpt_top u_dpt_top(.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .ce_i(ce_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr));

    dpt_host u_dpt_host(.sys_clk_i(sys_clk_i), .pready_i(pready),
        .pslverr_i(pslverr), .prdata_i(prdata), .psel_o(psel),
        .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
        .pwdata_o(pwdata), .pstrb_o(pstrb));

    ////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus(input logic wr, input logic [11:0] a,
        input logic [31:0] d, input logic [3:0] s);
        u_dpt_host.xfer(wr, a, d, s, rd, er, ok);
        if (!ok)
        begin
            fails++;
            $display("Error pready expected 1 seen 0");
            wrap_up();
        end
    endtask

    function automatic logic [7:0] exp_byte(input logic [23:0] a);
        case (a)
            24'h00000C: return 8'h30;
            24'h00000D: return 8'h00;
            24'h00000E: return 8'h00;
            24'h000030: return 8'hE5;
            24'h000031: return 8'h20;
            24'h000032: return 8'hF1;
            24'h000037: return 8'h07;
            24'h000038: return 8'h44;
            24'h000039: return 8'hEB;
            24'h00003A: return 8'h08;
            24'h00003B: return 8'h6B;
            24'h00003C: return 8'h08;
            24'h00003D: return 8'h3B;
            24'h00003E: return 8'h42;
            24'h00003F: return 8'hBB;
            24'h000040: return 8'hFE;
            24'h000046: return 8'h00;
            24'h00004A: return 8'h44;
            24'h00004B: return 8'hEB;
            24'h00004C: return 8'h0C;
            24'h00004D: return 8'h20;
            24'h00004E: return 8'h0F;
            24'h00004F: return 8'h52;
            24'h000050: return 8'h10;
            24'h000051: return 8'hD8;
            24'h000052: return 8'h00;
            default: return 8'hFF;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    task automatic t_refuse();
        bus(1'b0, 12'h000, 32'h00000000, 4'h0);
        chk("cmd reset", 32'h00000000, rd);
        bus(1'b0, 12'h004, 32'h00000000, 4'h0);
        chk("closed read err", 32'h00000001, {31'h0, er});
        chk("closed read data", 32'h00000000, rd);
        bus(1'b0, 12'h010, 32'h00000000, 4'h0);
        chk("unmapped err", 32'h00000001, {31'h0, er});
        bus(1'b1, 12'h00C, 32'h12345678, 4'hF);
        chk("dwrd write err", 32'h00000001, {31'h0, er});
        bus(1'b1, 12'h000, 32'h5A000030, 4'h3);
        chk("part strobe err", 32'h00000001, {31'h0, er});
        bus(1'b0, 12'h008, 32'h00000000, 4'h0);
        chk("stat idle", 32'h00000000, rd);
        $display("t_refuse done");
    endtask

    task automatic t_header();
        logic [23:0] a;
        bus(1'b1, 12'h000, 32'h5A00000C, 4'hF);
        for (a = 24'h00000C; a <= 24'h00000E; a++)
        begin
            bus(1'b0, 12'h004, 32'h00000000, 4'h0);
            chk("pointer byte", {24'h000000, exp_byte(a)}, rd);
        end
        bus(1'b0, 12'h008, 32'h00000000, 4'h0);
        chk("stat offset", 32'h00000F01, rd);
        bus(1'b1, 12'h000, 32'h5A00000C, 4'hF);
        bus(1'b0, 12'h00C, 32'h00000000, 4'h0);
        chk("pointer word", 32'hFF000030, rd);
        $display("t_header done");
    endtask

    task automatic t_stream();
        logic [23:0] a;
        bus(1'b1, 12'h000, 32'h5A000030, 4'hF);
        for (a = 24'h000030; a <= 24'h000053; a++)
        begin
            bus(1'b0, 12'h004, 32'h00000000, 4'h0);
            chk("table byte", {24'h000000, exp_byte(a)}, rd);
        end
        bus(1'b0, 12'h008, 32'h00000000, 4'h0);
        chk("stat end", 32'h00005401, rd);
        bus(1'b1, 12'h000, 32'h5A000030, 4'hF);
        for (a = 24'h000030; a <= 24'h000053; a += 24'h000004)
        begin
            bus(1'b0, 12'h00C, 32'h00000000, 4'h0);
            chk("table word", {exp_byte(a + 24'h3), exp_byte(a + 24'h2),
                exp_byte(a + 24'h1), exp_byte(a)}, rd);
        end
        $display("t_stream done");
    endtask

    task automatic t_freeze();
        bus(1'b1, 12'h000, 32'h5A00004C, 4'hF);
        @(posedge sys_clk_i);
        ce_i <= 1'b0;
        // Clock enable held low across the access; answer must wait
        fork
            bus(1'b0, 12'h004, 32'h00000000, 4'h0);
            begin
                repeat (6) @(posedge sys_clk_i);
                ce_i <= 1'b1;
            end
        join
        chk("frozen byte", 32'h0000000C, rd);
        bus(1'b0, 12'h004, 32'h00000000, 4'h0);
        chk("next byte", 32'h00000020, rd);
        $display("t_freeze done");
    endtask

    task automatic t_close();
        bus(1'b1, 12'h000, 32'h03000030, 4'hF);
        bus(1'b0, 12'h000, 32'h00000000, 4'h0);
        chk("cmd readback", 32'h03000030, rd);
        bus(1'b0, 12'h008, 32'h00000000, 4'h0);
        chk("bad flag", 32'h00000002, {24'h0, rd[7:0]});
        bus(1'b0, 12'h004, 32'h00000000, 4'h0);
        chk("wrong op err", 32'h00000001, {31'h0, er});
        bus(1'b1, 12'h008, 32'h00000002, 4'hF);
        bus(1'b1, 12'h000, 32'h5A000030, 4'hF);
        bus(1'b1, 12'h008, 32'h00000001, 4'hF);
        bus(1'b0, 12'h008, 32'h00000000, 4'h0);
        chk("closed flags", 32'h00000000, {24'h0, rd[7:0]});
        bus(1'b0, 12'h00C, 32'h00000000, 4'h0);
        chk("closed word err", 32'h00000001, {31'h0, er});
        $display("t_close done");
    endtask

    // Reset in mid-session must close it and clear the answer
    task automatic t_reset();
        bus(1'b1, 12'h000, 32'h5A000040, 4'hF);
        bus(1'b0, 12'h004, 32'h00000000, 4'h0);
        chk("byte before reset", 32'h000000FE, rd);
        @(posedge sys_clk_i);
        rst_b_i <= 1'b0;
        @(posedge sys_clk_i);
        chk("reset prdata", 32'h00000000, prdata);
        chk("reset flags", 32'h00000000, {30'h0, pready, pslverr});
        @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        bus(1'b0, 12'h008, 32'h00000000, 4'h0);
        chk("stat after reset", 32'h00000000, rd);
        bus(1'b0, 12'h000, 32'h00000000, 4'h0);
        chk("cmd after reset", 32'h00000000, rd);
        bus(1'b0, 12'h004, 32'h00000000, 4'h0);
        chk("closed after reset", 32'h00000001, {31'h0, er});
        $display("t_reset done");
    endtask

    initial
    begin
        repeat (2) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        t_refuse();
        t_header();
        t_stream();
        t_freeze();
        t_close();
        t_reset();
        wrap_up();
    end
endmodule
